// ---- core/pcsr_config_space.sv ----
/*
 Configuration space register set of the PCI target: identity, status and
 command, class, window base, subsystem ids and interrupt fields.
 Assumes the target logic on clk decodes configuration cycles into cfgReq
 pulses and reports parity, system error and target abort events as pulses
 on clk. Loaded identity values arrive from an external memory loader on its
 own clock eeClk with its own synchronous reset eeRstn.
*/
`timescale 1ns/10ps
module pcsr_config_space (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cfgReq,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgBe,
   input wire logic [31:0] cfgWdata,
   output logic [31:0] cfgRdata,
   output logic cfgAck,
   input wire logic parityErr,
   input wire logic systemErr,
   input wire logic targetAbort,
   input wire logic memReq,
   input wire logic [31:0] memAddr,
   output logic memHit,
   output logic memEnable,
   output logic [21:0] windowBase,
   output logic serrOe,
   output logic perrOe,
   input wire logic eeClk,
   input wire logic eeRstn,
   input wire logic eeLoadStb,
   input wire logic [15:0] eeDeviceId,
   input wire logic [15:0] eeVendorId,
   input wire logic [15:0] eeSubsysId,
   input wire logic [15:0] eeSubsysVendorId,
   output logic eeBusy
);

   typedef enum logic {EE_IDLE, EE_WAIT} pcsr_ee_e;

   // Merge write data into an old word under byte enables
   function automatic logic [31:0] beMerge(input logic [31:0] oldW, input logic [31:0] newW,
                                           input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      beMerge = (newW & m) | (oldW & ~m);
   endfunction

   // Loader domain state
   pcsr_ee_e eeState_q, eeState_d;
   logic eeReqTog_q, eeReqTog_d;
   logic [63:0] eeHold_q, eeHold_d;
   logic eeAckSync1_q, eeAckSync2_q;
   logic eeBusy_q;

   // Bus clock domain state
   logic reqSync1_q, reqSync2_q, reqSeen_q;
   logic eePresent_q, eePresent_d;
   logic [15:0] ldDevice_q, ldDevice_d, ldVendor_q, ldVendor_d;
   logic [15:0] subsysId_q, subsysId_d, subsysVen_q, subsysVen_d;
   logic parity_q, parity_d, sysErr_q, sysErr_d, tAbort_q, tAbort_d;
   logic serrEn_q, serrEn_d, perrEn_q, perrEn_d, memEn_q, memEn_d;
   logic [21:0] bar_q, bar_d;
   logic [7:0] intLine_q, intLine_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, memHit_q, serrOe_q, perrOe_q;

   // Loader handshake: capture one load, hold it until the bus side acks
   wire eeAccept = (eeState_q == EE_IDLE) & eeLoadStb;
   wire eeAcked = (eeState_q == EE_WAIT) & (eeAckSync2_q == eeReqTog_q);
   assign eeHold_d = eeAccept ? {eeDeviceId, eeVendorId, eeSubsysId, eeSubsysVendorId} : eeHold_q;
   assign eeReqTog_d = eeAccept ? ~eeReqTog_q : eeReqTog_q;
   always_comb begin
      case (eeState_q)
         EE_IDLE: eeState_d = eeAccept ? EE_WAIT : EE_IDLE;
         EE_WAIT: eeState_d = eeAcked ? EE_IDLE : EE_WAIT;
         default: eeState_d = EE_IDLE;
      endcase
   end

   // Loader domain flops
   always_ff @(posedge eeClk) begin
      if (!eeRstn) begin
         eeState_q <= EE_IDLE;
         eeReqTog_q <= 1'b0;
         eeHold_q <= 64'h0000000000000000;
         eeAckSync1_q <= 1'b0;
         eeAckSync2_q <= 1'b0;
         eeBusy_q <= 1'b0;
      end else begin
         eeState_q <= eeState_d;
         eeReqTog_q <= eeReqTog_d;
         eeHold_q <= eeHold_d;
         eeAckSync1_q <= reqSeen_q;
         eeAckSync2_q <= eeAckSync1_q;
         eeBusy_q <= (eeState_d == EE_WAIT);
      end
   end

   // New load seen on the bus side; hold words are stable by then
   wire newLoad = reqSync2_q ^ reqSeen_q;
   assign eePresent_d = newLoad | eePresent_q;                 // R16
   assign ldDevice_d = newLoad ? eeHold_q[63:48] : ldDevice_q;  // R3
   assign ldVendor_d = newLoad ? eeHold_q[47:32] : ldVendor_q;  // R3
   assign subsysId_d = newLoad ? eeHold_q[31:16] : subsysId_q;  // R17
   assign subsysVen_d = newLoad ? eeHold_q[15:0] : subsysVen_q; // R17

   // Address decode, configuration cycles only
   wire selIdentity = cfgAddr[7:2] == pcsr_pkg::OFS_IDENTITY[7:2];
   wire selStatCmd = cfgAddr[7:2] == pcsr_pkg::OFS_STATCMD[7:2];
   wire selClassRev = cfgAddr[7:2] == pcsr_pkg::OFS_CLASSREV[7:2];
   wire selHdrMisc = cfgAddr[7:2] == pcsr_pkg::OFS_HDRMISC[7:2];
   wire selMemBase = cfgAddr[7:2] == pcsr_pkg::OFS_MEMBASE[7:2];
   wire selUnused = cfgAddr[7:2] == pcsr_pkg::OFS_UNUSEDBASE[7:2];
   wire selSubsys = cfgAddr[7:2] == pcsr_pkg::OFS_SUBSYS[7:2];
   wire selIntr = cfgAddr[7:2] == pcsr_pkg::OFS_INTR[7:2];
   wire cfgWr = cfgReq & cfgWrite;
   wire wrStatCmd = cfgWr & selStatCmd;
   wire wrMemBase = cfgWr & selMemBase;
   wire wrIntr = cfgWr & selIntr;
   wire [31:0] wrOnes = cfgWdata & {{8{cfgBe[3]}}, {8{cfgBe[2]}}, {8{cfgBe[1]}}, {8{cfgBe[0]}}};

   // Sticky flags: a new event wins over a same-cycle clear
   assign parity_d = parityErr | (parity_q & ~(wrStatCmd & wrOnes[pcsr_pkg::STS_PARITY])); // R4
   assign sysErr_d = systemErr | (sysErr_q & ~(wrStatCmd & wrOnes[pcsr_pkg::STS_SYSERR])); // R5
   assign tAbort_d = targetAbort | tAbort_q;                                               // R6

   // Command word writable bits
   wire [31:0] cmdOld = {23'h000000, serrEn_q, 1'b0, perrEn_q, 4'h0, memEn_q, 1'b0};
   wire [31:0] cmdNew = beMerge(cmdOld, cfgWdata, cfgBe);
   assign serrEn_d = wrStatCmd ? cmdNew[pcsr_pkg::CMD_SERR_EN] : serrEn_q; // R9
   assign perrEn_d = wrStatCmd ? cmdNew[pcsr_pkg::CMD_PERR_EN] : perrEn_q; // R10
   assign memEn_d = wrStatCmd ? cmdNew[pcsr_pkg::CMD_MEM_EN] : memEn_q;    // R11

   // Window base and interrupt line
   wire [31:0] barWord = {bar_q, 10'h000};                    // R2
   wire [31:0] barNew = beMerge(barWord, cfgWdata, cfgBe);
   assign bar_d = wrMemBase ? barNew[31:pcsr_pkg::BAR_LSB] : bar_q; // R1
   wire [31:0] intWord = {16'h0000, pcsr_pkg::INT_PIN, intLine_q};  // R18
   wire [31:0] intNew = beMerge(intWord, cfgWdata, cfgBe);
   assign intLine_d = wrIntr ? intNew[7:0] : intLine_q;

   // Read words
   wire [15:0] devIdRd = eePresent_q ? ldDevice_q : pcsr_pkg::DEF_DEVICE_ID; // R16
   wire [15:0] venIdRd = eePresent_q ? ldVendor_q : pcsr_pkg::DEF_VENDOR_ID; // R16
   wire [31:0] identityRd = {devIdRd, venIdRd};                             // R3
   wire [15:0] statusRd = {parity_q, sysErr_q, 2'b00, tAbort_q, 2'b00, 1'b0, 1'b1, 7'h00}; // R7 R8
   wire [31:0] statCmdRd = {statusRd, 7'h00, serrEn_q, 1'b0, perrEn_q, 4'h0, memEn_q, 1'b0}; // R12
   wire [31:0] classRevRd = {pcsr_pkg::CLASS_CODE, pcsr_pkg::DEF_REVISION}; // R13
   wire [31:0] subsysRd = {subsysId_q, subsysVen_q};                        // R17
   // Unmapped offsets read zero
   assign rdata_d = !(cfgReq & ~cfgWrite) ? rdata_q :
                    selIdentity ? identityRd :
                    selStatCmd ? statCmdRd :
                    selClassRev ? classRevRd :
                    selHdrMisc ? pcsr_pkg::HDRMISC_VALUE :  // R14
                    selMemBase ? barWord :
                    selUnused ? pcsr_pkg::UNUSED_VALUE :    // R15
                    selSubsys ? subsysRd :
                    selIntr ? intWord : 32'h00000000;       // R19

   // Memory window decode, only while memory space is enabled
   wire memMatch = memEn_q & memReq & (memAddr[31:pcsr_pkg::BAR_LSB] == bar_q); // R11

   // Bus domain flops, all writable and sticky bits reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reqSync1_q <= 1'b0;
         reqSync2_q <= 1'b0;
         reqSeen_q <= 1'b0;
         eePresent_q <= pcsr_pkg::RST_FLAG;
         ldDevice_q <= pcsr_pkg::RST_LOADED_ID;
         ldVendor_q <= pcsr_pkg::RST_LOADED_ID;
         subsysId_q <= pcsr_pkg::RST_SUBSYS;
         subsysVen_q <= pcsr_pkg::RST_SUBSYS;
         parity_q <= pcsr_pkg::RST_FLAG;  // R20
         sysErr_q <= pcsr_pkg::RST_FLAG;  // R20
         tAbort_q <= pcsr_pkg::RST_FLAG;  // R6
         serrEn_q <= pcsr_pkg::RST_FLAG;
         perrEn_q <= pcsr_pkg::RST_FLAG;
         memEn_q <= pcsr_pkg::RST_FLAG;
         bar_q <= pcsr_pkg::RST_BAR;
         intLine_q <= pcsr_pkg::RST_INTLINE;
         rdata_q <= pcsr_pkg::RST_RDATA;
         ack_q <= 1'b0;
         memHit_q <= 1'b0;
         serrOe_q <= 1'b0;
         perrOe_q <= 1'b0;
      end else begin
         reqSync1_q <= eeReqTog_q;
         reqSync2_q <= reqSync1_q;
         reqSeen_q <= reqSync2_q;
         eePresent_q <= eePresent_d;
         ldDevice_q <= ldDevice_d;
         ldVendor_q <= ldVendor_d;
         subsysId_q <= subsysId_d;
         subsysVen_q <= subsysVen_d;
         parity_q <= parity_d;
         sysErr_q <= sysErr_d;
         tAbort_q <= tAbort_d;
         serrEn_q <= serrEn_d;
         perrEn_q <= perrEn_d;
         memEn_q <= memEn_d;
         bar_q <= bar_d;
         intLine_q <= intLine_d;
         rdata_q <= rdata_d;
         ack_q <= cfgReq;
         memHit_q <= memMatch;                 // R1
         serrOe_q <= serrEn_q & systemErr;     // R9
         perrOe_q <= perrEn_q & parityErr;     // R10
      end
   end

   // Outputs straight from flops
   assign cfgRdata = rdata_q;
   assign cfgAck = ack_q;
   assign memHit = memHit_q;
   assign memEnable = memEn_q;
   assign windowBase = bar_q;
   assign serrOe = serrOe_q;
   assign perrOe = perrOe_q;
   assign eeBusy = eeBusy_q;
endmodule

// ---- core/pcsr_pkg.sv ----
/*
 Constants for the configuration space register set: offsets, field
 positions, reset values and fixed read values. Assumes nothing.

 // What this block does
 // R1: Host writes memory window base at 0x10; device decodes accesses against it.
 // R2: Window register bits 31:10 writable, bits 9:0 read zero, claiming 1K.
 // R3: Offset 0x00 gives device id high, vendor id low; defaults unless loaded.
 // R4: Status bit 31 sets on parity error, clears only by writing one.
 // R5: Status bit 30 sets on system error, clears only by writing one.
 // R6: Status bit 27 sets on target abort termination, zero after reset.
 // R7: Status bit 23 reads one, fast back-to-back target support.
 // R8: Status bit 24 master data error reads zero, read-only.
 // R9: Command bit 8 writable, resets zero, gates the system error driver.
 // R10: Command bit 6 writable, resets zero, gates parity error response.
 // R11: Command bit 1 writable, resets zero, gates memory space response.
 // R12: Command bit 0 reads zero; no I/O space claim.
 // R13: Offset 0x08 gives fixed serial controller class code and revision.
 // R14: Offset 0x0C reads all zero bytes, read-only.
 // R15: Offset 0x14 reads zero, read-only.
 // R16: Identity takes loaded values only after an external memory load.
 // R17: Offset 0x2C holds loaded subsystem ids, reset to zero.
 // R18: Offset 0x3C bits 15:8 read 0x01, interrupt pin A.
 // R19: Reach only by configuration cycles; reserved bits read zero.
 // R20: Writable and sticky bits return to reset values on reset.
*/
package pcsr_pkg;
   // Byte offsets
   localparam logic [7:0] OFS_IDENTITY = 8'h00;
   localparam logic [7:0] OFS_STATCMD = 8'h04;
   localparam logic [7:0] OFS_CLASSREV = 8'h08;
   localparam logic [7:0] OFS_HDRMISC = 8'h0C;
   localparam logic [7:0] OFS_MEMBASE = 8'h10;
   localparam logic [7:0] OFS_UNUSEDBASE = 8'h14;
   localparam logic [7:0] OFS_SUBSYS = 8'h2C;
   localparam logic [7:0] OFS_INTR = 8'h3C;
   // Status and command field positions
   localparam int STS_PARITY = 31;
   localparam int STS_SYSERR = 30;
   localparam int STS_TABORT = 27;
   localparam int STS_MDPERR = 24;
   localparam int STS_FASTB2B = 23;
   localparam int CMD_SERR_EN = 8;
   localparam int CMD_PERR_EN = 6;
   localparam int CMD_MEM_EN = 1;
   localparam int CMD_IO_EN = 0;
   localparam int BAR_LSB = 10;
   // Fixed read values
   localparam logic [23:0] CLASS_CODE = 24'h070002;
   localparam logic [7:0] INT_PIN = 8'h01;
   localparam logic [31:0] HDRMISC_VALUE = 32'h00000000;
   localparam logic [31:0] UNUSED_VALUE = 32'h00000000;
   // Identity defaults, values arbitrary
   localparam logic [15:0] DEF_DEVICE_ID = 16'h5A01;
   localparam logic [15:0] DEF_VENDOR_ID = 16'h1DF0;
   // Revision, value arbitrary
   localparam logic [7:0] DEF_REVISION = 8'h01;
   // Reset values
   localparam logic RST_FLAG = 1'b0;
   localparam logic [21:0] RST_BAR = 22'h000000;
   localparam logic [15:0] RST_SUBSYS = 16'h0000;
   localparam logic [15:0] RST_LOADED_ID = 16'h0000;
   localparam logic [7:0] RST_INTLINE = 8'h00;
   localparam logic [31:0] RST_RDATA = 32'h00000000;
endpackage

// ---- tb/pcsr_config_space_assertions.sv ----
/*
 Checker on the clk-domain ports of the register set.
 Assumes binding into pcsr_config_space; loader domain unwatched.
*/
`timescale 1ns/10ps
module pcsr_config_space_assertions (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cfgReq,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [31:0] cfgRdata,
   input wire logic cfgAck,
   input wire logic parityErr,
   input wire logic systemErr,
   input wire logic memReq,
   input wire logic memHit,
   input wire logic memEnable,
   input wire logic serrOe,
   input wire logic perrOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Read of one dword by index
   sequence s_rd(int a); cfgReq && !cfgWrite && cfgAddr[7:2] == a; endsequence
   property p_ack; cfgReq |=> cfgAck; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_noack; !cfgReq |=> !cfgAck; endproperty
   a_noack: assert property (p_noack) else $error("stray ack");
   property p_stat; s_rd(1) |=> cfgRdata[23] && !cfgRdata[24] && !cfgRdata[0]; endproperty
   a_stat: assert property (p_stat) else $error("fixed status bits");
   property p_class; s_rd(2) |=> cfgRdata[31:8] == 24'h070002; endproperty
   a_class: assert property (p_class) else $error("class code");
   property p_zero; s_rd(3) or s_rd(5) |=> cfgRdata == 32'h00000000; endproperty
   a_zero: assert property (p_zero) else $error("zero word");
   property p_bar; s_rd(4) |=> cfgRdata[9:0] == 10'h000; endproperty
   a_bar: assert property (p_bar) else $error("window low bits");
   property p_par; parityErr ##1 s_rd(1) |=> cfgRdata[31]; endproperty
   a_par: assert property (p_par) else $error("parity flag");
   property p_sys; systemErr ##1 s_rd(1) |=> cfgRdata[30]; endproperty
   a_sys: assert property (p_sys) else $error("system error flag");
   property p_hit; memHit |-> $past(memReq) && $past(memEnable); endproperty
   a_hit: assert property (p_hit) else $error("hit not enabled");
   property p_serr; serrOe |-> $past(systemErr); endproperty
   a_serr: assert property (p_serr) else $error("serr drive");
   property p_perr; perrOe |-> $past(parityErr); endproperty
   a_perr: assert property (p_perr) else $error("perr drive");
endmodule
bind pcsr_config_space pcsr_config_space_assertions pcsr_config_space_assertions_i (
   .clk(clk), .rstn(rstn), .cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
   .cfgRdata(cfgRdata), .cfgAck(cfgAck), .parityErr(parityErr), .systemErr(systemErr),
   .memReq(memReq), .memHit(memHit), .memEnable(memEnable), .serrOe(serrOe), .perrOe(perrOe));

// ---- tb/pcsr_config_space_tb_top.sv ----
/*
 Bench: host config cycles, events, window decode, identity load.
 Assumes pcsr_ee_model on the link clock.
*/
`timescale 1ns/10ps
module pcsr_config_space_tb_top;
   logic clk = 1'b0, rstn = 1'b0, eeClk = 1'b0, eeRstn = 1'b0, seen = 1'b0;
   logic cfgReq = 1'b0, cfgWrite = 1'b0, parityErr = 1'b0, systemErr = 1'b0, targetAbort = 1'b0, memReq = 1'b0;
   logic [7:0] cfgAddr = 8'h00;
   logic [3:0] cfgBe = 4'h0;
   logic [31:0] cfgWdata = 32'h0, memAddr = 32'h0, cfgRdata;
   logic cfgAck, memHit, memEnable, serrOe, perrOe, eeLoadStb, eeBusy;
   logic [21:0] windowBase;
   logic [15:0] eeDeviceId, eeVendorId, eeSubsysId, eeSubsysVendorId;
   int errorCnt = 0, nChecks = 0;
   // Constants, so the tables below never see them uninitialised
   localparam logic [31:0] ident = {pcsr_pkg::DEF_DEVICE_ID, pcsr_pkg::DEF_VENDOR_ID};
   localparam logic [31:0] cls = {pcsr_pkg::CLASS_CODE, pcsr_pkg::DEF_REVISION};
   logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h2C, 8'h3C, 8'h18};
   logic [31:0] rv [9] = '{ident, 32'h00800000, cls, 0, 0, 0, 0, 32'h00000100, 0};
   logic [31:0] ov [9] = '{ident, 32'h00800142, cls, 0, 32'hFFFFFC00, 0, 0, 32'h000001FF, 0};
   // Clocks, the link clock off phase
   always #5 clk = ~clk;
   initial #3 forever #62.5 eeClk = ~eeClk;
   initial #300 eeRstn = 1'b1;
   pcsr_config_space pcsr_config_space_i (.clk(clk), .rstn(rstn), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
      .cfgAddr(cfgAddr), .cfgBe(cfgBe), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .cfgAck(cfgAck),
      .parityErr(parityErr), .systemErr(systemErr), .targetAbort(targetAbort), .memReq(memReq),
      .memAddr(memAddr), .memHit(memHit), .memEnable(memEnable), .windowBase(windowBase), .serrOe(serrOe),
      .perrOe(perrOe), .eeClk(eeClk), .eeRstn(eeRstn), .eeLoadStb(eeLoadStb), .eeDeviceId(eeDeviceId),
      .eeVendorId(eeVendorId), .eeSubsysId(eeSubsysId), .eeSubsysVendorId(eeSubsysVendorId), .eeBusy(eeBusy));
   pcsr_ee_model pcsr_ee_model_i (.eeClk(eeClk), .eeLoadStb(eeLoadStb), .eeDeviceId(eeDeviceId),
      .eeVendorId(eeVendorId), .eeSubsysId(eeSubsysId), .eeSubsysVendorId(eeSubsysVendorId));
   // Compare and count
   task automatic chk(string what, logic [31:0] s, logic [31:0] e);
      nChecks++;
      if (s !== e) begin
         errorCnt++;
         $display("MISMATCH %s exp %h seen %h", what, e, s);
      end
   endtask
   // One config cycle, ack and read data one cycle later
   task automatic cfg(logic wr, logic [7:0] a, logic [3:0] be, logic [31:0] d, logic [31:0] e);
      @(negedge clk);
      {cfgReq, cfgWrite, cfgAddr, cfgBe, cfgWdata} = {1'b1, wr, a, be, d};
      {parityErr, systemErr, targetAbort} = 3'b000;
      @(negedge clk);
      cfgReq = 1'b0;
      chk("ack", {31'h0, cfgAck}, 32'h1);
      if (!wr) chk($sformatf("rd %h", a), cfgRdata, e);
   endtask
   task automatic hit(logic [31:0] a, logic e);
      @(negedge clk);
      {memReq, memAddr} = {1'b1, a};
      @(negedge clk);
      memReq = 1'b0;
      chk("hit", {31'h0, memHit}, {31'h0, e});
   endtask
   task automatic ev(logic [1:0] e);
      @(negedge clk);
      {parityErr, systemErr, targetAbort} = 3'b111;
      @(negedge clk);
      {parityErr, systemErr, targetAbort} = 3'b000;
      chk("oe", {30'h0, perrOe, serrOe}, {30'h0, e});
   endtask
   task automatic endSim();
      $display("checks %0d mismatches %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errorCnt++;
      endSim();
   end
   initial begin
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      foreach (adr[i]) cfg(1'b0, adr[i], 4'h0, 32'h0, rv[i]);
      foreach (adr[i]) cfg(1'b1, adr[i], 4'hF, 32'hFFFFFFFF, 32'h0);
      foreach (adr[i]) cfg(1'b0, adr[i], 4'h0, 32'h0, ov[i]);
      chk("base", {10'h0, windowBase}, 32'h003FFFFF);
      chk("memEn", {31'h0, memEnable}, 32'h1);
      $display("test registers done");
      cfg(1'b1, 8'h10, 4'hF, 32'h12345400, 32'h0);
      hit(32'h123457FC, 1'b1);
      hit(32'h12345800, 1'b0);
      cfg(1'b1, 8'h04, 4'hF, 32'h0, 32'h0);
      hit(32'h12345400, 1'b0);
      $display("test decode done");
      cfg(1'b1, 8'h04, 4'hF, 32'h00000100, 32'h0);
      ev(2'b01);
      cfg(1'b1, 8'h04, 4'hF, 32'h00000040, 32'h0);
      ev(2'b10);
      cfg(1'b1, 8'h04, 4'hF, 32'h00000142, 32'h0);
      ev(2'b11);
      @(negedge clk) {parityErr, systemErr, targetAbort} = 3'b111;
      cfg(1'b0, 8'h04, 4'h0, 32'h0, 32'hC8800142);
      cfg(1'b1, 8'h04, 4'h7, 32'hFFFFFFFF, 32'h0);
      cfg(1'b0, 8'h04, 4'h0, 32'h0, 32'hC8800142);
      cfg(1'b1, 8'h04, 4'hF, 32'hC8000000, 32'h0);
      cfg(1'b0, 8'h04, 4'h0, 32'h0, 32'h08800000);
      ev(2'b00);
      rstn = 1'b0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      foreach (adr[i]) cfg(1'b0, adr[i], 4'h0, 32'h0, rv[i]);
      $display("test events done");
      pcsr_ee_model_i.load();
      for (int i = 0; i < 200 && !(seen && !eeBusy); i++) begin
         @(negedge clk);
         seen = seen | eeBusy;
      end
      chk("load", {31'h0, seen && !eeBusy}, 32'h1);
      if (!seen || eeBusy) endSim();
      repeat (8) @(negedge clk);
      cfg(1'b0, 8'h00, 4'h0, 32'h0, {pcsr_ee_model_i.DEV, pcsr_ee_model_i.VEN});
      cfg(1'b0, 8'h2C, 4'h0, 32'h0, {pcsr_ee_model_i.SUB, pcsr_ee_model_i.SVEN});
      $display("test load done");
      endSim();
   end
endmodule

// ---- tb/pcsr_ee_model.sv ----
/*
 Identity loader model on the link clock: hands over one id set.
 Assumes eeClk from the bench and an idle loader at each call.
*/
`timescale 1ns/10ps
module pcsr_ee_model #(
   parameter logic [15:0] DEV = 16'hB7C3, // Values arbitrary
   parameter logic [15:0] VEN = 16'h2E91,
   parameter logic [15:0] SUB = 16'h4D26,
   parameter logic [15:0] SVEN = 16'h6A58
) (
   input wire logic eeClk,
   output logic eeLoadStb,
   output logic [15:0] eeDeviceId,
   output logic [15:0] eeVendorId,
   output logic [15:0] eeSubsysId,
   output logic [15:0] eeSubsysVendorId
);
   // Idle words show the inverse so a late capture shows
   initial begin
      eeLoadStb = 1'b0;
      {eeDeviceId, eeVendorId, eeSubsysId, eeSubsysVendorId} = ~{DEV, VEN, SUB, SVEN};
   end
   // One strobe with valid words for one eeClk cycle
   task automatic load();
      @(negedge eeClk);
      eeLoadStb = 1'b1;
      {eeDeviceId, eeVendorId, eeSubsysId, eeSubsysVendorId} = {DEV, VEN, SUB, SVEN};
      @(negedge eeClk);
      eeLoadStb = 1'b0;
      {eeDeviceId, eeVendorId, eeSubsysId, eeSubsysVendorId} = ~{DEV, VEN, SUB, SVEN};
   endtask
endmodule
